// file: two_pkg.sv
`default_nettype none
package two_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] TWO_IDX_TMR_LOW = 6'h00;
  localparam logic [5:0] TWO_IDX_TMR_CTRL = 6'h01;
  localparam logic [5:0] TWO_IDX_PRESCALE = 6'h02;
  localparam logic [5:0] TWO_IDX_BUZZER_CONTROL = 6'h05;
  localparam logic [5:0] TWO_IDX_INFRARED_CONTROL = 6'h06;
  localparam logic [5:0] TWO_IDX_PWM_SECOND_CONTROL = 6'h0A;
  localparam logic [5:0] TWO_IDX_PWM_SECOND_DUTY_LOW = 6'h0C;
  localparam logic [5:0] TWO_IDX_TIMER_AND_DUTY_HIGH = 6'h0D;
  localparam logic [5:0] TWO_IDX_PWM_THIRD_FOURTH_HIGH = 6'h0E;
  localparam int TWO_ADDR_LSB = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TWO_BZ_EN_BIT = 7;
  localparam int TWO_IR_EN_BIT = 0;
  localparam int TWO_IR_HIGH_BIT = 1;
  localparam int TWO_IR_POL_BIT = 2;
  localparam int TWO_IR_XTAL_BIT = 7;
  localparam int TWO_PWM_OEN_BIT = 7;
  localparam int TWO_PWM_OAL_BIT = 6;
  localparam int TWO_TC_EN_BIT = 0;
  localparam int TWO_TC_RELOAD_BIT = 1;
  localparam int TWO_TC_ONESHOT_BIT = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] TWO_BZ_RESET = 8'h0F;
  localparam logic [7:0] TWO_IR_RESET = 8'h00;
  localparam logic [1:0] TWO_PWM_CTRL_RESET = 2'h0;
  localparam logic [2:0] TWO_TC_RESET = 3'h0;
  localparam logic [2:0] TWO_PRESCALE_RESET = 3'h7;
  localparam logic [9:0] TWO_TMR_WRAP = 10'h0FF;

  // ---------------------------------------------------------------
  // Carrier division ratios, in IR input clock cycles
  // ---------------------------------------------------------------
  localparam logic [6:0] TWO_DIV_FAST_HIGH = 7'd64;
  localparam logic [6:0] TWO_DIV_FAST_LOW = 7'd96;
  localparam logic [6:0] TWO_DIV_SLOW_HIGH = 7'd8;
  localparam logic [6:0] TWO_DIV_SLOW_LOW = 7'd12;

  // Down timer run state
  typedef enum logic [1:0] {TS_IDLE, TS_RUN, TS_DONE} two_tmr_state_type;
endpackage
`default_nettype wire

// file: two_ir_carrier.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Carrier divider: square wave of period div_ratio cycles
// ---------------------------------------------------------------
module two_ir_carrier (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [6:0] div_ratio,
  // Carrier
  output logic carrier
);
  import two_pkg::*;

  logic [6:0] cnt_r; // Cycles into the current period
  logic carrier_r; // Carrier level

  // Count through one period, restart at its end or when stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'h00;
    end else if (!run || cnt_r >= div_ratio - 7'h01) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // High for the first half of each period; ratios are all even
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_r <= 1'b0;
    end else begin
      carrier_r <= run && (cnt_r < (div_ratio >> 1));
    end
  end

  assign carrier = carrier_r;
endmodule
`default_nettype wire

// file: two_top.sv
// ---------------------------------------------------------------
// Notes on behaviour
// - Codes 0-7: prescaler output, divide 2 to 256
// - Codes 8-15: timer bit given by code
// - Buzzer drives only when enabled; off after reset
// - IR carrier only while IR enable set
// - High select gives 57 kHz, else 38 kHz
// - Polarity picks pin data level that gates carrier
// - Crystal type picks dividers; ignored on internal
// - Carrier clocked only from high-frequency oscillator
// - Internal or 3.58 MHz: divide 64 or 96
// - 455 kHz crystal: divide 8 or 12
// - Second PWM polarity: set means active low
// - Output enable routes PWM to pin, else GPIO
// - Frame period from 10-bit timer reload value
// - Duty is high bits 3:2 plus duty byte
// - Writing high bits 5:4 sets load bits 9:8
// - Reading high bits 5:4 gives running timer bits
// - High register holds second and first duty tops
// - Third/fourth register holds their duty tops
// - PWM inactive until timer equals duty, till underflow
// - Reload on underflow if selected, else from 0xFF
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module two_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator status pins
  input wire logic hosc_active,
  input wire logic hosc_is_crystal,
  // Port data bit that gates the carrier (same clock)
  input wire logic ir_pin_data,
  // Waveform pins
  output logic buzzer_out,
  output logic ir_carrier_out,
  output logic pwm_second_pin,
  output logic pwm_second_pin_oe
);
  import two_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] prdata_r; // Read data held for the answer
  logic pready_r; // One wait state then ready
  logic pslverr_r; // Unmapped address flag
  logic [7:0] buzzer_control_r; // Enable and frequency code
  logic [7:0] infrared_control_r; // Carrier controls
  logic [1:0] pwm_second_control_r; // Out enable, active low
  logic [7:0] pwm_second_duty_r; // Duty low byte
  logic [3:0] duty_top_r; // Second and first duty tops
  logic [3:0] pwm_third_fourth_r; // Fourth and third duty tops
  logic [9:0] tmr_reload_r; // 10-bit load value
  logic [9:0] tmr_r; // Running timer
  logic [2:0] tmr_ctrl_r; // Oneshot, reload, enable
  logic [2:0] prescale_sel_r; // Timer tick rate
  logic [7:0] pre_cnt_r; // Free prescaler counter
  two_tmr_state_type tstate_r; // Timer run state
  logic pwm_act_r; // PWM active phase
  logic [1:0] hosc_sync_r; // Oscillator running, synchronised
  logic [1:0] xtal_sync_r; // Crystal mode, synchronised
  logic buzzer_r; // Buzzer pin level
  logic ir_r; // IR pin level
  logic pwm_pin_r; // PWM pin level
  logic pwm_oe_r; // PWM pin ownership
  logic access; // Access phase with answer ready
  logic wr_en; // Write takes effect
  logic [5:0] idx; // Register index
  logic mapped; // Address hits a register
  logic tick; // Timer count tick
  logic underflow; // Timer passes zero
  logic [8:0] tick_mask; // Prescaler bits for the tick
  logic [9:0] pwm_duty; // Full second channel duty
  logic [6:0] ir_div; // Carrier division ratio
  logic ir_run; // Carrier generator running
  logic ir_carrier; // Raw carrier
  logic buzz_src; // Selected buzzer source
  logic [31:0] rd_mux; // Read data before capture

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign idx = paddr[7:TWO_ADDR_LSB];
  assign access = psel && penable && pready_r;
  assign wr_en = access && pwrite && mapped;

  // Address decode; write-only registers still count as mapped
  always_comb begin
    case (idx)
      TWO_IDX_TMR_LOW, TWO_IDX_TMR_CTRL, TWO_IDX_PRESCALE,
      TWO_IDX_BUZZER_CONTROL, TWO_IDX_INFRARED_CONTROL,
      TWO_IDX_PWM_SECOND_CONTROL, TWO_IDX_PWM_SECOND_DUTY_LOW,
      TWO_IDX_TIMER_AND_DUTY_HIGH, TWO_IDX_PWM_THIRD_FOURTH_HIGH: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      TWO_IDX_TMR_LOW: begin
        rd_mux[7:0] = tmr_r[7:0];
      end
      TWO_IDX_TMR_CTRL: begin
        rd_mux[2:0] = tmr_ctrl_r;
        rd_mux[5:4] = tstate_r;
      end
      TWO_IDX_PRESCALE: begin
        rd_mux[2:0] = prescale_sel_r;
      end
      TWO_IDX_PWM_SECOND_CONTROL: begin
        rd_mux[7:6] = pwm_second_control_r;
      end
      TWO_IDX_TIMER_AND_DUTY_HIGH: begin
        // Live timer bits, not the load value
        rd_mux[5:0] = {tmr_r[9:8], duty_top_r};
      end
      TWO_IDX_PWM_THIRD_FOURTH_HIGH: begin
        rd_mux[3:0] = pwm_third_fourth_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after the access phase opens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Plain control bytes; a write takes effect at the ready edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buzzer_control_r <= TWO_BZ_RESET;
      infrared_control_r <= TWO_IR_RESET;
      pwm_second_control_r <= TWO_PWM_CTRL_RESET;
      pwm_second_duty_r <= 8'h00;
      duty_top_r <= 4'h0;
      pwm_third_fourth_r <= 4'h0;
      tmr_ctrl_r <= TWO_TC_RESET;
      prescale_sel_r <= TWO_PRESCALE_RESET;
    end else if (wr_en) begin
      case (idx)
        TWO_IDX_BUZZER_CONTROL: begin
          buzzer_control_r <= pwdata[7:0];
        end
        TWO_IDX_INFRARED_CONTROL: begin
          infrared_control_r <= pwdata[7:0];
        end
        TWO_IDX_PWM_SECOND_CONTROL: begin
          pwm_second_control_r <= pwdata[7:6];
        end
        TWO_IDX_PWM_SECOND_DUTY_LOW: begin
          pwm_second_duty_r <= pwdata[7:0];
        end
        TWO_IDX_TIMER_AND_DUTY_HIGH: begin
          duty_top_r <= pwdata[3:0];
        end
        TWO_IDX_PWM_THIRD_FOURTH_HIGH: begin
          pwm_third_fourth_r <= pwdata[3:0];
        end
        TWO_IDX_TMR_CTRL: begin
          tmr_ctrl_r <= pwdata[2:0];
        end
        TWO_IDX_PRESCALE: begin
          prescale_sel_r <= pwdata[2:0];
        end
        default: begin
          tmr_ctrl_r <= tmr_ctrl_r;
        end
      endcase
    end
  end

  // Reload value; high bits replace load bits 9:8 only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_reload_r <= TWO_TMR_WRAP;
    end else if (wr_en && idx == TWO_IDX_TMR_LOW) begin
      tmr_reload_r[7:0] <= pwdata[7:0];
    end else if (wr_en && idx == TWO_IDX_TIMER_AND_DUTY_HIGH) begin
      tmr_reload_r[9:8] <= pwdata[5:4];
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and down timer
  // ---------------------------------------------------------------
  // Free running so the buzzer taps always toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // Tick once per 2^(sel+1) cycles
  assign tick_mask = (9'h002 << prescale_sel_r) - 9'h001;
  assign tick = &(pre_cnt_r | ~tick_mask[7:0]);
  assign underflow = tick && tstate_r == TS_RUN && tmr_r == 10'h000;

  // Run state: one-shot mode parks at zero after one pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tstate_r <= TS_IDLE;
    end else begin
      case (tstate_r)
        TS_IDLE: begin
          if (tmr_ctrl_r[TWO_TC_EN_BIT]) begin
            tstate_r <= TS_RUN;
          end
        end
        TS_RUN: begin
          if (!tmr_ctrl_r[TWO_TC_EN_BIT]) begin
            tstate_r <= TS_IDLE;
          end else if (underflow && tmr_ctrl_r[TWO_TC_ONESHOT_BIT]) begin
            tstate_r <= TS_DONE;
          end
        end
        TS_DONE: begin
          if (!tmr_ctrl_r[TWO_TC_EN_BIT]) begin
            tstate_r <= TS_IDLE;
          end
        end
        default: begin
          tstate_r <= TS_IDLE;
        end
      endcase
    end
  end

  // Counter; a low-byte write also loads the running value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_r <= TWO_TMR_WRAP;
    end else if (wr_en && idx == TWO_IDX_TMR_LOW) begin
      tmr_r <= {tmr_reload_r[9:8], pwdata[7:0]};
    end else if (tstate_r == TS_IDLE && tmr_ctrl_r[TWO_TC_EN_BIT]) begin
      tmr_r <= tmr_reload_r;
    end else if (underflow && !tmr_ctrl_r[TWO_TC_ONESHOT_BIT]) begin
      if (tmr_ctrl_r[TWO_TC_RELOAD_BIT]) begin
        tmr_r <= tmr_reload_r;
      end else begin
        tmr_r <= TWO_TMR_WRAP;
      end
    end else if (tick && tstate_r == TS_RUN && tmr_r != 10'h000) begin
      tmr_r <= tmr_r - 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // Second PWM channel
  // ---------------------------------------------------------------
  assign pwm_duty = {duty_top_r[3:2], pwm_second_duty_r};

  // Active from duty match until underflow; idle when stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_act_r <= 1'b0;
    end else if (tstate_r != TS_RUN || underflow) begin
      pwm_act_r <= 1'b0;
    end else if (tmr_r == pwm_duty) begin
      pwm_act_r <= 1'b1;
    end
  end

  // Pin stage; a clear enable hands the pin back to the port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_pin_r <= 1'b0;
      pwm_oe_r <= 1'b0;
    end else begin
      pwm_pin_r <= pwm_act_r ^ pwm_second_control_r[TWO_PWM_OAL_BIT - 6];
      pwm_oe_r <= pwm_second_control_r[TWO_PWM_OEN_BIT - 6];
    end
  end

  // ---------------------------------------------------------------
  // Buzzer
  // ---------------------------------------------------------------
  // Prescaler tap n toggles at clk/2^(n+1); upper codes use timer bits
  always_comb begin
    if (buzzer_control_r[3]) begin
      buzz_src = tmr_r[buzzer_control_r[2:0]];
    end else begin
      buzz_src = pre_cnt_r[buzzer_control_r[2:0]];
    end
  end

  // Registered so a code change cannot glitch the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buzzer_r <= 1'b0;
    end else begin
      buzzer_r <= buzzer_control_r[TWO_BZ_EN_BIT] && buzz_src;
    end
  end

  // ---------------------------------------------------------------
  // Infrared carrier
  // ---------------------------------------------------------------
  // Oscillator status comes from outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hosc_sync_r <= 2'b00;
      xtal_sync_r <= 2'b00;
    end else begin
      hosc_sync_r <= {hosc_sync_r[0], hosc_active};
      xtal_sync_r <= {xtal_sync_r[0], hosc_is_crystal};
    end
  end

  // Divider choice; crystal type matters only in crystal mode
  always_comb begin
    if (!xtal_sync_r[1] || infrared_control_r[TWO_IR_XTAL_BIT]) begin
      ir_div = infrared_control_r[TWO_IR_HIGH_BIT] ?
        TWO_DIV_FAST_HIGH : TWO_DIV_FAST_LOW;
    end else begin
      ir_div = infrared_control_r[TWO_IR_HIGH_BIT] ?
        TWO_DIV_SLOW_HIGH : TWO_DIV_SLOW_LOW;
    end
  end

  // Stops whenever the high oscillator is not running
  assign ir_run = infrared_control_r[TWO_IR_EN_BIT] && hosc_sync_r[1];

  two_ir_carrier u_carrier (
    .clk(clk),
    .rst(rst),
    .run(ir_run),
    .div_ratio(ir_div),
    .carrier(ir_carrier)
  );

  // Gate by pin data at the selected polarity, then register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_r <= 1'b0;
    end else begin
      ir_r <= ir_run && ir_carrier &&
        (ir_pin_data ^ infrared_control_r[TWO_IR_POL_BIT]);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign buzzer_out = buzzer_r;
  assign ir_carrier_out = ir_r;
  assign pwm_second_pin = pwm_pin_r;
  assign pwm_second_pin_oe = pwm_oe_r;
endmodule
`default_nettype wire

// file: two_props.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker for the waveform block
// ---------------------------------------------------------------
module two_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Oscillator and pin data
  input wire logic hosc_active,
  input wire logic hosc_is_crystal,
  input wire logic ir_pin_data,
  // Waveform pins
  input wire logic buzzer_out,
  input wire logic ir_carrier_out,
  input wire logic pwm_second_pin,
  input wire logic pwm_second_pin_oe
);
  import two_pkg::*;
  logic [5:0] idx;
  logic first_acc, wr_done, mapped, wo_idx;
  // Shadow copies of the enable and polarity bits
  logic bz_en_r, ir_en_r, ir_pol_r, oe_r;
  assign idx = paddr[7:2];
  assign first_acc = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped = idx inside {6'h00, 6'h01, 6'h02, 6'h05, 6'h06, 6'h0A, 6'h0C, 6'h0D, 6'h0E};
  assign wo_idx = idx inside {6'h05, 6'h06, 6'h0C};
  // Track writes so gating can be judged without seeing the body
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bz_en_r <= 1'b0;
      ir_en_r <= 1'b0;
      ir_pol_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (wr_done && idx == 6'h05) begin
      bz_en_r <= pwdata[TWO_BZ_EN_BIT];
    end else if (wr_done && idx == 6'h06) begin
      ir_en_r <= pwdata[TWO_IR_EN_BIT];
      ir_pol_r <= pwdata[TWO_IR_POL_BIT];
    end else if (wr_done && idx == 6'h0A) begin
      oe_r <= pwdata[TWO_PWM_OEN_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_apb_one_wait: assert property (first_acc |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // Read data only means something on a read; a refused write keeps the last read word
  a_unmapped_refused: assert property (first_acc && !mapped |=>
    pready && pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (first_acc && mapped |=> !pslverr)
    else $error("error on mapped access");
  a_wo_read_zero: assert property (first_acc && !pwrite && wo_idx |=> prdata == 32'h0)
    else $error("write-only read not zero");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_buzzer_gate: assert property ((!bz_en_r)[*3] |-> !buzzer_out)
    else $error("buzzer driven while disabled");
  a_ir_gate: assert property ((!ir_en_r)[*3] |-> !ir_carrier_out)
    else $error("carrier driven while disabled");
  a_ir_polarity: assert property ((ir_pin_data == ir_pol_r)[*3] |-> !ir_carrier_out)
    else $error("carrier on wrong pin level");
  a_ir_osc_off: assert property ((!hosc_active)[*5] |-> !ir_carrier_out)
    else $error("carrier without oscillator");
  a_pwm_oe_follow: assert property (1'b1 |-> pwm_second_pin_oe == $past(oe_r))
    else $error("pin enable does not follow bit");
  c_buzzer_write: cover property (wr_done && idx == 6'h05);
  c_unmapped: cover property (first_acc && !mapped);
  c_ir_rise: cover property ($rose(ir_carrier_out));
  c_oe_rise: cover property ($rose(pwm_second_pin_oe));
endmodule
bind two_top two_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .hosc_active(hosc_active), .hosc_is_crystal(hosc_is_crystal),
  .ir_pin_data(ir_pin_data), .buzzer_out(buzzer_out), .ir_carrier_out(ir_carrier_out),
  .pwm_second_pin(pwm_second_pin), .pwm_second_pin_oe(pwm_second_pin_oe));
`default_nettype wire

// file: two_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Load on one port pin: measures the wave it receives
// ---------------------------------------------------------------
module two_pin_load (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin level seen by the load
  input wire logic pin,
  // Rise-to-rise period, high time and rise count, in clocks
  output logic [15:0] period,
  output logic [15:0] high_time,
  output logic [15:0] rises
);
  logic pin_r;
  logic [15:0] cnt_r;
  // Counts wrap on very slow waves; the tests stay far below that
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
      cnt_r <= 16'h0;
      period <= 16'h0;
      high_time <= 16'h0;
      rises <= 16'h0;
    end else begin
      pin_r <= pin;
      cnt_r <= cnt_r + 16'h1;
      if (pin && !pin_r) begin
        period <= cnt_r;
        rises <= rises + 16'h1;
        cnt_r <= 16'h1;
      end
      if (!pin && pin_r) begin
        high_time <= cnt_r;
      end
    end
  end
endmodule
`default_nettype wire

// file: two_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module two_top_tb;
  import two_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic hosc_active, hosc_is_crystal, ir_pin_data;
  logic buzzer_out, ir_carrier_out, pwm_second_pin, pwm_second_pin_oe;
  logic [15:0] bz_per, bz_hi, bz_n, ir_per, ir_hi, ir_n, pw_per, pw_hi, pw_n;
  int err_total, cmp_count, cyc, i, p;
  // Carrier table: first three internal, the rest crystal
  logic [7:0] ir_cfg [7] = '{8'h01, 8'h03, 8'h81, 8'h03, 8'h01, 8'h83, 8'h81};
  logic [7:0] ir_exp [7] = '{8'h60, 8'h40, 8'h60, 8'h08, 8'h0C, 8'h40, 8'h60};
  two_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hosc_active(hosc_active), .hosc_is_crystal(hosc_is_crystal), .ir_pin_data(ir_pin_data),
    .buzzer_out(buzzer_out), .ir_carrier_out(ir_carrier_out),
    .pwm_second_pin(pwm_second_pin), .pwm_second_pin_oe(pwm_second_pin_oe));
  two_pin_load u_bz (.clk(clk), .rst(rst), .pin(buzzer_out), .period(bz_per),
    .high_time(bz_hi), .rises(bz_n));
  two_pin_load u_ir (.clk(clk), .rst(rst), .pin(ir_carrier_out), .period(ir_per),
    .high_time(ir_hi), .rises(ir_n));
  two_pin_load u_pw (.clk(clk), .rst(rst), .pin(pwm_second_pin), .period(pw_per),
    .high_time(pw_hi), .rises(pw_n));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) err_total++;
  endtask
  // No rising edge may reach the chosen load for a while
  task automatic quiet(input int w);
    logic [15:0] a;
    wt(20);
    a = (w == 0) ? bz_n : (w == 1) ? ir_n : pw_n;
    wt(300);
    check((w == 0) ? bz_n : (w == 1) ? ir_n : pw_n, a);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hosc_active, hosc_is_crystal, ir_pin_data} = 3'b101;
    {err_total, cmp_count, cyc} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(6'h0A, 1'b0, 8'h00); check(rd, 32'h0);
    apb(6'h0E, 1'b1, 8'h0A); apb(6'h0E, 1'b0, 8'h00); check(rd, 32'h0A);
    // Timer idle at 0x0FF, so the top bits read back as zero
    apb(6'h0D, 1'b1, 8'h3F); apb(6'h0D, 1'b0, 8'h00); check(rd, 32'h0F);
    apb(6'h0A, 1'b1, 8'hC0); apb(6'h0A, 1'b0, 8'h00); check(rd, 32'hC0);
    apb(6'h05, 1'b0, 8'h00); check(err, 1'b0); check(rd, 32'h0);
    apb(6'h3F, 1'b1, 8'hFF); check(err, 1'b1);
    apb(6'h3F, 1'b0, 8'h00); check(err, 1'b1); check(rd, 32'h0);
    $display("register test done");
    // Free-running timer, one tick every two clocks
    apb(6'h0D, 1'b1, 8'h00); apb(6'h02, 1'b1, 8'h00);
    apb(6'h00, 1'b1, 8'hFF); apb(6'h01, 1'b1, 8'h01);
    for (i = 0; i < 16; i++) begin
      p = (i < 8) ? (1 << (i + 1)) : (1 << (i - 6));
      apb(6'h05, 1'b1, 8'h80 | i[7:0]);
      wt(3 * p + 40);
      check(bz_per, p[15:0]);
    end
    apb(6'h05, 1'b1, 8'h0F); quiet(0);
    $display("buzzer test done");
    for (i = 0; i < 7; i++) begin
      hosc_is_crystal <= (i >= 3);
      apb(6'h06, 1'b1, ir_cfg[i]);
      wt(400);
      check(ir_per, ir_exp[i]);
      check(ir_hi, ir_exp[i] >> 1);
    end
    apb(6'h06, 1'b1, 8'h85); quiet(1);
    ir_pin_data <= 1'b0; wt(400); check(ir_per, 16'h60);
    hosc_active <= 1'b0; quiet(1);
    hosc_active <= 1'b1; apb(6'h06, 1'b1, 8'h84); quiet(1);
    $display("carrier test done");
    // Duty and reload are complete before the pin is handed over
    apb(6'h01, 1'b1, 8'h00); apb(6'h0A, 1'b1, 8'h00); apb(6'h0C, 1'b1, 8'h10);
    apb(6'h00, 1'b1, 8'h20); apb(6'h01, 1'b1, 8'h03); apb(6'h0A, 1'b1, 8'h80);
    wt(300); check(pwm_second_pin_oe, 1'b1);
    // The match is seen one clock into its tick, so active spans 2*duty+1 clocks
    check({pw_per, pw_hi}, {16'h42, 16'h21});
    apb(6'h0A, 1'b1, 8'hC0); wt(300); check(pw_hi, 16'h21);
    apb(6'h0D, 1'b1, 8'h14); wt(1500); check({pw_per, pw_hi}, {16'h242, 16'h21});
    apb(6'h0D, 1'b1, 8'h00); apb(6'h0A, 1'b1, 8'h80); apb(6'h01, 1'b1, 8'h01);
    wt(1600); check({pw_per, pw_hi}, {16'h200, 16'h21});
    apb(6'h0A, 1'b1, 8'h00); wt(2); check(pwm_second_pin_oe, 1'b0);
    $display("pwm test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
